// ==== verilog/ctt_pkg.sv ====
// constants, register map and field layout of the counter/timer block
package ctt_pkg;

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] CTT_OFS_PRELOAD_LO = 8'h00;
   localparam logic [7:0] CTT_OFS_PRELOAD_HI = 8'h04;
   localparam logic [7:0] CTT_OFS_AUX_CTRL   = 8'h08;
   localparam logic [7:0] CTT_OFS_INT_STATUS = 8'h0C;
   localparam logic [7:0] CTT_OFS_INT_MASK   = 8'h10;
   localparam logic [7:0] CTT_OFS_CMD_A      = 8'h14;
   localparam logic [7:0] CTT_OFS_CMD_B      = 8'h18;
   localparam logic [7:0] CTT_OFS_START      = 8'h1C;
   localparam logic [7:0] CTT_OFS_STOP       = 8'h20;
   localparam logic [7:0] CTT_OFS_STATE      = 8'h24;

   // ------------------------------------------------------------------
   // field positions and codes
   // ------------------------------------------------------------------
   localparam int         CTT_SEL_LSB       = 4;     // mode/clock field
   localparam int         CTT_SEL_MSB       = 6;
   localparam int         CTT_SEL_TIMER_BIT = 2;     // within the field
   localparam int         CTT_FLAG_BIT      = 3;     // ready flag, mask
   localparam int         CTT_CMD_LSB       = 4;     // command nibble
   localparam logic [3:0] CTT_CMD_TO_ON     = 4'hA;
   localparam logic [3:0] CTT_CMD_TO_OFF    = 4'hC;

   // clock source codes (low two bits of the select field)
   localparam logic [1:0] CTT_SRC_PIN       = 2'h0;
   localparam logic [1:0] CTT_SRC_PIN_DIV   = 2'h1;
   localparam logic [1:0] CTT_SRC_CLK       = 2'h2;
   localparam logic [1:0] CTT_SRC_CLK_DIV   = 2'h3;

   // ------------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------------
   localparam logic [7:0]  CTT_RST_PRELOAD  = 8'h00;
   localparam logic [2:0]  CTT_RST_SEL      = 3'h6;  // timer, pclk
   localparam logic [15:0] CTT_RST_COUNT    = 16'hFFFF;
   localparam logic [15:0] CTT_COUNT_LAST   = 16'h0001;
   localparam logic [3:0]  CTT_PRESCALE_MAX = 4'hF;  // divide by 16

   // restart sequence after a receiver load
   typedef enum logic [1:0] {
      CTT_RS_IDLE,
      CTT_RS_STOP,
      CTT_RS_LOAD
   } ctt_restart_e;

endpackage

// ==== verilog/ctt_counter_timer.sv ====
// 16-bit counter/timer with receive time-out, behind an APB slave
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ctt_counter_timer
   import ctt_pkg::*;
#(
   parameter int CW = 16
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output var  logic [31:0]   prdata,
   output var  logic          pready,
   output var  logic          pslverr,
   input  wire logic          input_pin_two,
   input  wire logic          rx_load_a,
   input  wire logic          rx_load_b,
   output var  logic          count_out,
   output var  logic          count_irq_n
);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [7:0]    preload_lo_q;
   logic [7:0]    preload_hi_q;
   logic [2:0]    sel_q;
   logic          mask_q;
   logic          flag_q;
   logic          flag_d;
   logic          to_a_q;
   logic          to_b_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic          run_q;
   logic          run_d;
   logic          out_q;
   logic          out_d;
   ctt_restart_e  rs_q;
   ctt_restart_e  rs_d;
   logic [3:0]    pre_q;
   logic          pin_s1_q;
   logic          pin_s2_q;
   logic          pin_s3_q;
   logic [31:0]   rdata_q;

   // checks below sample on pclk and rest while reset is low
   default clocking ast_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   wire logic setup_w   = psel & ~penable;
   wire logic access_w  = psel & penable;
   wire logic wr_w      = access_w & pwrite;
   wire logic rd_w      = access_w & ~pwrite;
   wire logic hit_lo    = (paddr == CTT_OFS_PRELOAD_LO);
   wire logic hit_hi    = (paddr == CTT_OFS_PRELOAD_HI);
   wire logic hit_aux   = (paddr == CTT_OFS_AUX_CTRL);
   wire logic hit_isr   = (paddr == CTT_OFS_INT_STATUS);
   wire logic hit_imr   = (paddr == CTT_OFS_INT_MASK);
   wire logic hit_cra   = (paddr == CTT_OFS_CMD_A);
   wire logic hit_crb   = (paddr == CTT_OFS_CMD_B);
   wire logic hit_start = (paddr == CTT_OFS_START);
   wire logic hit_stop  = (paddr == CTT_OFS_STOP);
   wire logic hit_state = (paddr == CTT_OFS_STATE);
   wire logic mapped_w  = hit_lo | hit_hi | hit_aux | hit_isr | hit_imr |
                          hit_cra | hit_crb | hit_start | hit_stop |
                          hit_state;

   // slave answers in the access cycle; no wait states
   assign pready  = 1'b1;
   assign pslverr = access_w & ~mapped_w;
   assign prdata  = rdata_q;

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   wire logic [3:0] cmd_w = pwdata[CTT_CMD_LSB +: 4];
   wire logic to_on_a  = wr_w & hit_cra & (cmd_w == CTT_CMD_TO_ON);
   wire logic to_off_a = wr_w & hit_cra & (cmd_w == CTT_CMD_TO_OFF);
   wire logic to_on_b  = wr_w & hit_crb & (cmd_w == CTT_CMD_TO_ON);
   wire logic to_off_b = wr_w & hit_crb & (cmd_w == CTT_CMD_TO_OFF);
   wire logic to_on_w  = to_on_a | to_on_b;
   wire logic to_act_w = to_a_q | to_b_q;

   // start and stop are read side effects; data bus ignored
   wire logic start_w  = rd_w & hit_start & ~to_act_w;
   wire logic stop_w   = rd_w & hit_stop & ~to_act_w;

   // either enabled receiver restarts the time-out count
   wire logic rx_w = (to_a_q & rx_load_a) | (to_b_q & rx_load_b);

   // ------------------------------------------------------------------
   // mode and clock source
   // ------------------------------------------------------------------
   // time-out mode forces the one-shot behaviour on top of the field
   wire logic       timer_w   = sel_q[CTT_SEL_TIMER_BIT] & ~to_act_w;
   wire logic [1:0] src_w     = sel_q[1:0];
   wire logic       pin_rise  = pin_s2_q & ~pin_s3_q;
   wire logic [CW-1:0] preload_w = {preload_hi_q, preload_lo_q};

   // raw edge before the optional divide by 16
   wire logic raw_tick = (src_w == CTT_SRC_CLK) | (src_w == CTT_SRC_CLK_DIV)
                         ? 1'b1 : pin_rise;
   wire logic div_src  = (src_w == CTT_SRC_PIN_DIV) |
                         (src_w == CTT_SRC_CLK_DIV);
   wire logic tick_w   = raw_tick & (~div_src | (pre_q == CTT_PRESCALE_MAX));

   // input pin synchroniser plus one stage for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= input_pin_two;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // prescaler advances only on raw source edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= '0;
      end else if (raw_tick) begin
         pre_q <= pre_q + 4'h1;
      end
   end

   // ------------------------------------------------------------------
   // counting engine
   // ------------------------------------------------------------------
   wire logic last_w = (count_q == CTT_COUNT_LAST);

   // precedence: time-out enable, receiver restart, start, ticks
   always_comb begin
      count_d = count_q;
      run_d   = run_q;
      out_d   = out_q;
      rs_d    = rs_q;
      if (to_on_w) begin
         run_d = 1'b0;
         rs_d  = CTT_RS_IDLE;
      end else if (rx_w) begin
         rs_d  = CTT_RS_STOP;
      end else if (start_w) begin
         count_d = preload_w;
         run_d   = 1'b1;
         out_d   = 1'b1;
      end else if (tick_w) begin
         if (rs_q == CTT_RS_STOP) begin
            // one more counter clock, then stop
            run_d = 1'b0;
            rs_d  = CTT_RS_LOAD;
         end else if (rs_q == CTT_RS_LOAD) begin
            count_d = preload_w;
            run_d   = 1'b1;
            out_d   = 1'b1;
            rs_d    = CTT_RS_IDLE;
         end else if (timer_w) begin
            // square wave: reload and invert at terminal count
            if (last_w) begin
               count_d = preload_w;
               out_d   = ~out_q;
            end else begin
               count_d = count_q - 1'b1;
            end
         end else if (run_q & ~stop_w) begin
            // one-shot: wraps past zero with no further effect
            count_d = count_q - 1'b1;
            if (last_w) begin
               out_d = 1'b0;
            end
         end
      end
      // stop halts only the one-shot; timer ticks are not lost
      if (stop_w) begin
         run_d = 1'b0;
      end
   end

   // output falling edge is the ready event
   wire logic fall_w = out_q & ~out_d;

   // set wins over every clear
   always_comb begin
      flag_d = flag_q;
      if (stop_w | to_on_w | rx_w) begin
         flag_d = 1'b0;
      end
      if (fall_w) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= CTT_RST_COUNT;
         run_q   <= 1'b0;
         out_q   <= 1'b1;
         rs_q    <= CTT_RS_IDLE;
         flag_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         run_q   <= run_d;
         out_q   <= out_d;
         rs_q    <= rs_d;
         flag_q  <= flag_d;
      end
   end

   // square wave drives baud clock selectors and output pins
   assign count_out   = out_q;
   assign count_irq_n = ~(flag_q & mask_q);

   // ------------------------------------------------------------------
   // software-written registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preload_lo_q <= CTT_RST_PRELOAD;
         preload_hi_q <= CTT_RST_PRELOAD;
         sel_q        <= CTT_RST_SEL;
         mask_q       <= 1'b0;
      end else if (wr_w) begin
         if (hit_lo) preload_lo_q <= pwdata[7:0];
         if (hit_hi) preload_hi_q <= pwdata[7:0];
         if (hit_aux) sel_q <= pwdata[CTT_SEL_MSB:CTT_SEL_LSB];
         if (hit_imr) mask_q <= pwdata[CTT_FLAG_BIT];
      end
   end

   // time-out enables per channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_a_q <= 1'b0;
         to_b_q <= 1'b0;
      end else begin
         if (to_on_a) to_a_q <= 1'b1;
         else if (to_off_a) to_a_q <= 1'b0;
         if (to_on_b) to_b_q <= 1'b1;
         else if (to_off_b) to_b_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // read data, captured in the setup cycle
   // ------------------------------------------------------------------
   // count bytes show the live count only outside timer mode
   wire logic [CW-1:0] view_w = timer_w ? preload_w : count_q;
   wire logic [31:0] rd_mux =
        hit_lo    ? {24'h000000, view_w[7:0]} :
        hit_hi    ? {24'h000000, view_w[15:8]} :
        hit_aux   ? {25'h0000000, sel_q, 4'h0} :
        hit_isr   ? {28'h0000000, flag_q, 3'h0} :
        hit_imr   ? {28'h0000000, mask_q, 3'h0} :
        hit_state ? {27'h0000000, rs_q != CTT_RS_IDLE, run_q, out_q,
                     to_b_q, to_a_q} :
        32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h00000000;
      end else if (setup_w & ~pwrite) begin
         rdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   AST_FALL_SETS_FLAG: assert property (
      $fell(out_q) |-> flag_q)
      else $error("ready flag not set on output fall");

   AST_ISR_SHOWS: assert property (
      setup_w && !pwrite && hit_isr && flag_q |=> prdata[CTT_FLAG_BIT])
      else $error("status read missed the ready flag");

   AST_LO_WRITE: assert property (
      wr_w && hit_lo |=> preload_lo_q == $past(pwdata[7:0]))
      else $error("low preload byte not written");

   AST_HI_WRITE: assert property (
      wr_w && hit_hi |=> preload_hi_q == $past(pwdata[7:0]))
      else $error("high preload byte not written");

   AST_SEL_WRITE: assert property (
      wr_w && hit_aux |=> sel_q == $past(pwdata[CTT_SEL_MSB:CTT_SEL_LSB]))
      else $error("mode and clock field not written");

   AST_START_RELOADS: assert property (
      start_w && !to_on_w && !rx_w |=> count_q == $past(preload_w))
      else $error("start did not reload count");

   AST_STOP_CLEARS: assert property (
      stop_w && !fall_w |=> !flag_q)
      else $error("stop did not clear ready flag");

   AST_STOP_HALTS: assert property (
      stop_w && !timer_w |=> !run_q)
      else $error("stop did not halt the one-shot");

   AST_TIMER_STOP_TICKS: assert property (
      timer_w && stop_w && tick_w && !last_w && rs_q == CTT_RS_IDLE
      |=> count_q == $past(count_q) - 1'b1)
      else $error("stop cost the timer a tick");

   AST_TIMER_TOGGLES: assert property (
      timer_w && tick_w && last_w && rs_q == CTT_RS_IDLE && !start_w &&
      !stop_w && !rx_w && !to_on_w
      |=> out_q != $past(out_q) && count_q == $past(preload_w))
      else $error("timer missed toggle and reload");

   AST_COUNT_ENDS: assert property (
      !timer_w && run_q && tick_w && last_w && rs_q == CTT_RS_IDLE &&
      !start_w && !stop_w && !rx_w && !to_on_w
      |=> count_q == '0 && !out_q && flag_q)
      else $error("one-shot did not end at zero");

   AST_LIVE_READ: assert property (
      setup_w && !pwrite && hit_lo && !timer_w
      |=> prdata[7:0] == $past(count_q[7:0]))
      else $error("count byte read not live");

   AST_TO_IGNORES_START: assert property (
      to_act_w && rd_w && hit_start && rs_q == CTT_RS_IDLE && !run_q &&
      !rx_w && !to_on_w
      |=> $stable(count_q) && !run_q)
      else $error("start acted in time-out mode");

   AST_TO_IGNORES_STOP: assert property (
      to_act_w && rd_w && hit_stop && !rx_w && !to_on_w && !fall_w
      |=> flag_q == $past(flag_q))
      else $error("stop acted in time-out mode");

   AST_RX_RESTART: assert property (
      rx_w && !to_on_w |=> rs_q == CTT_RS_STOP && !flag_q)
      else $error("receiver load did not restart");

   AST_RX_STOP_TICK: assert property (
      rs_q == CTT_RS_STOP && tick_w && !rx_w && !to_on_w
      |=> rs_q == CTT_RS_LOAD && !run_q)
      else $error("restart did not stop after one tick");

   AST_RESTART_LOAD: assert property (
      rs_q == CTT_RS_LOAD && tick_w && !rx_w && !to_on_w
      |=> run_q && out_q && count_q == $past(preload_w))
      else $error("restart did not reload and run");

   AST_RX_WITHDRAWS: assert property (
      rx_w && !to_on_w |=> count_irq_n)
      else $error("receiver load left interrupt pending");

   AST_TO_ON_HOLDS: assert property (
      to_on_w |=> !run_q && !flag_q && rs_q == CTT_RS_IDLE)
      else $error("time-out enable did not clear and stop");

   AST_TO_B_OFF: assert property (
      wr_w && hit_crb && cmd_w == CTT_CMD_TO_OFF |=> !to_b_q)
      else $error("time-out disable not taken");

   AST_ISR_ZERO: assert property (
      setup_w && !pwrite && hit_isr && !flag_q |=> prdata == 32'h00000000)
      else $error("status read not zero while idle");

endmodule

`default_nettype wire

// ==== verif/ctt_host.sv ====
// APB host model that drives the counter/timer register bus
`timescale 1ns/1ps
`default_nettype none

module ctt_host (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [7:0]  paddr,
   output var  logic [31:0] pwdata,
   output var  logic        hang
);
   // ---------------------------------------------------------------
   // idle bus at time zero
   // ---------------------------------------------------------------
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      hang    = 1'b0;
   end

   // one transfer; held until pready is seen high, bounded wait
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      int k;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wr ? d : 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd  = prdata;
      err = pslverr;
      if (k >= 50)
         hang <= 1'b1;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the counter/timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
   error_cnt++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
   import ctt_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        hang, err, rx_load_a, rx_load_b;
   logic        input_pin_two = 1'b0;
   logic        count_out, count_irq_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, rd0;
   int          error_cnt = 0, checked = 0, n, c, b, pc = 0;
   int          per[4] = '{6, 96, 1, 16};

   // ---------------------------------------------------------------
   // clock and a free external count clock, rising every 6 cycles
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      pc <= (pc == 2) ? 0 : pc + 1;
      if (pc == 2)
         input_pin_two <= ~input_pin_two;
   end

   ctt_counter_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_pin_two(input_pin_two), .rx_load_a(rx_load_a),
      .rx_load_b(rx_load_b), .count_out(count_out),
      .count_irq_n(count_irq_n));
   ctt_host i_host (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .hang(hang));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge hang) begin
      error_cnt++;
      stop_test();
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, rd, err);
   endtask
   task automatic rdr(input logic [7:0] a);
      i_host.xfer(1'b0, a, 32'h0, rd, err);
   endtask
   // count cycles until the output shows a level; a stall ends the run
   task automatic wait_out(input logic lvl, input int lim);
      #1;
      c = 0;
      while (count_out !== lvl && c < lim) begin
         @(posedge pclk);
         #1;
         c++;
      end
      if (c >= lim) begin
         error_cnt++;
         stop_test();
      end
   endtask
   // one receiver load pulse, one cycle wide
   task automatic rx(input bit chb);
      @(posedge pclk);
      if (chb)
         rx_load_b <= 1'b1;
      else
         rx_load_a <= 1'b1;
      @(posedge pclk);
      rx_load_a <= 1'b0;
      rx_load_b <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      rx_load_a = 1'b0;
      rx_load_b = 1'b0;
      void'($urandom(15));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and an unmapped place
      wait_out(1'b1, 4);
      rdr(CTT_OFS_AUX_CTRL);
      `CHK("aux", 32'h60, rd)
      rdr(CTT_OFS_INT_STATUS);
      `CHK("status", 32'h0, rd)
      rdr(8'h30);
      `CHK("unmapped", 2'b10, {err, |rd})
      $display("test reset done");
      // timer: divisor from a random baud, symmetric half periods
      b = 80000 + $urandom % 170000;
      n = (100000000 + 16 * b) / (32 * b);
      wr(CTT_OFS_PRELOAD_LO, 32'(n));
      wr(CTT_OFS_PRELOAD_HI, 32'h0);
      rdr(CTT_OFS_PRELOAD_LO);
      `CHK("pre_lo", 32'(n), rd)
      rdr(CTT_OFS_START);
      wait_out(1'b0, 70000);
      wait_out(1'b1, 200);
      `CHK("half_hi", n, c)
      wait_out(1'b0, 200);
      `CHK("half_lo", n, c)
      rdr(CTT_OFS_INT_STATUS);
      `CHK("flag", 32'h08, rd)
      rdr(CTT_OFS_STOP);
      rdr(CTT_OFS_INT_STATUS);
      `CHK("flag_stop", 32'h0, rd)
      wait_out(1'b1, 200);
      wait_out(1'b0, 200);
      `CHK("half_stop", n, c)
      rdr(CTT_OFS_INT_STATUS);
      `CHK("flag_again", 32'h08, rd)
      `CHK("irq_masked", 1'b1, count_irq_n)
      $display("test timer done");
      // counter: one-shot from every clock source
      for (int s = 0; s < 4; s++) begin
         wr(CTT_OFS_AUX_CTRL, 32'(s) << 4);
         rdr(CTT_OFS_START);
         #1;
         `CHK("started", 1'b1, count_out)
         wait_out(1'b0, n * per[s] + 200);
         `CHK("delay", 1'b1, c + per[s] >= n * per[s])
         `CHK("delay_max", 1'b1, c <= n * per[s] + per[s] + 8)
      end
      repeat (40) @(posedge pclk);
      rdr(CTT_OFS_STOP);
      rdr(CTT_OFS_PRELOAD_HI);
      `CHK("live_hi", 32'hFF, rd)
      rdr(CTT_OFS_PRELOAD_LO);
      rd0 = rd;
      repeat (20) @(posedge pclk);
      rdr(CTT_OFS_PRELOAD_LO);
      `CHK("live_lo", rd0, rd)
      $display("test counter done");
      // time-out: enable clears and holds, start is ignored
      wr(CTT_OFS_AUX_CTRL, 32'h20);
      wr(CTT_OFS_INT_MASK, 32'h08);
      rdr(CTT_OFS_START);
      wait_out(1'b0, n + 20);
      `CHK("irq_on", 1'b0, count_irq_n)
      wr(CTT_OFS_CMD_A, 32'hA0);
      rdr(CTT_OFS_START);
      repeat (3 * n) @(posedge pclk);
      rdr(CTT_OFS_INT_STATUS);
      `CHK("held", 32'h0, rd)
      `CHK("held_irq", 1'b1, count_irq_n)
      rx(1'b0);
      wait_out(1'b1, 20);
      `CHK("restart", 2, c)
      wait_out(1'b0, n + 20);
      `CHK("expiry", n, c)
      rdr(CTT_OFS_STOP);
      rdr(CTT_OFS_INT_STATUS);
      `CHK("stop_ign", 32'h08, rd)
      `CHK("to_irq", 1'b0, count_irq_n)
      rx(1'b0);
      #1;
      `CHK("irq_wd", 1'b1, count_irq_n)
      rdr(CTT_OFS_INT_STATUS);
      `CHK("spurious", 32'h0, rd)
      // both channels on: either load restarts the count
      wr(CTT_OFS_CMD_B, 32'hA0);
      rdr(CTT_OFS_STATE);
      `CHK("to_both", 2'b11, rd[1:0])
      for (int k = 0; k < 6; k++) begin
         rx(k[0]);
         repeat (n / 2) @(posedge pclk);
      end
      rdr(CTT_OFS_INT_STATUS);
      `CHK("no_exp_flag", 32'h0, rd)
      `CHK("no_expiry", 1'b1, count_out)
      wait_out(1'b0, n + 20);
      rdr(CTT_OFS_INT_STATUS);
      `CHK("both_exp", 32'h08, rd)
      wr(CTT_OFS_CMD_A, 32'hC0);
      wr(CTT_OFS_CMD_B, 32'hC0);
      rdr(CTT_OFS_STATE);
      `CHK("to_off", 2'b00, rd[1:0])
      rdr(CTT_OFS_STOP);
      rdr(CTT_OFS_INT_STATUS);
      `CHK("stop_back", 32'h0, rd)
      $display("test time-out done");
      stop_test();
   end
endmodule

`default_nettype wire
